//--- hw/bge_pkg.sv
package bge_pkg;

	// ************************************************************
	// Operations of the second branch group
	// ************************************************************
	typedef enum logic [3:0] {
		OP_CMP_ACC,
		OP_CMP_OPND,
		OP_BYTE_DECREMENT_BRANCH_NONZERO,
		OP_WORD_DECREMENT_BRANCH_NONZERO,
		OP_SWI_VECTOR,
		OP_SWI_ADDR16,
		OP_SOFTWARE_TRAP_FAR,
		OP_SOFTWARE_TRAP_FIXED,
		OP_INTERRUPT_RETURN,
		OP_QUICK_INTERRUPT_RETURN,
		OP_LINK,
		OP_UNLINK,
		OP_NEAR_SUBROUTINE_RETURN,
		OP_FAR_SUBROUTINE_RETURN
	} bge_op_e;

	typedef struct packed {
		logic i;
		logic s;
		logic t;
		logic n;
		logic z;
		logic v;
		logic c;
	} bge_ccr_s;

	typedef struct packed {
		bge_op_e op;
		logic is_word;
		logic is_mem;
		logic [15:0] acc;
		logic [15:0] opnd;
		logic [15:0] imm;
		logic [7:0] rel;
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] fp;
		logic [23:0] target;
		logic [15:0] stk_w0;
		logic [15:0] stk_w1;
		logic [15:0] stk_w2;
		logic [3:0] corr_a;
		logic [3:0] corr_b;
		logic [3:0] corr_c;
		bge_ccr_s ccr;
	} bge_req_s;

	typedef struct packed {
		logic [15:0] pc;
		logic [7:0] program_bank_register;
		logic pcb_we;
		logic [15:0] sp;
		logic [15:0] fp;
		bge_ccr_s ccr;
		logic [15:0] wb_data;
		logic wb_we;
		logic read_modify_write_marker;
		logic [15:0] push_data;
		logic push_we;
		logic taken;
		logic [23:0] vec_addr;
		logic vec_fetch;
	} bge_res_s;

	// ************************************************************
	// Cycle counts and layout
	// ************************************************************
	localparam int CNT_W = 8;
	localparam logic [7:0] CYC_CMP_TAKEN = 8'h04;
	localparam logic [7:0] CYC_CMP_NOT = 8'h03;
	localparam logic [7:0] CYC_CMPM_TAKEN = 8'h05;
	localparam logic [7:0] CYC_CMPM_NOT = 8'h04;
	localparam logic [7:0] CYC_DEC_TAKEN = 8'h05;
	localparam logic [7:0] CYC_DEC_NOT = 8'h04;
	localparam logic [7:0] CYC_DECM_TAKEN = 8'h06;
	localparam logic [7:0] CYC_DECM_NOT = 8'h05;
	localparam logic [7:0] CYC_INT_BASE = 8'h0c;
	localparam logic [7:0] CYC_LINK = 8'h06;
	localparam logic [7:0] CYC_UNLINK = 8'h05;
	localparam logic [7:0] CYC_RET_NEAR = 8'h04;
	localparam logic [7:0] CYC_RET_FAR = 8'h05;
	localparam logic [15:0] FRAME_BYTES = 16'h000c;
	localparam logic [23:0] VEC_BASE = 24'hfffffc;
	localparam logic [7:0] FIXED_VCT = 8'h09;
	localparam int PS_I_BIT = 6;
	localparam int PS_S_BIT = 5;
	localparam int PS_T_BIT = 4;
	localparam int PS_N_BIT = 3;
	localparam int PS_Z_BIT = 2;
	localparam int PS_V_BIT = 1;
	localparam int PS_C_BIT = 0;

endpackage

//--- hw/bge_cycle_timer.sv
`timescale 1ns/10ps
`default_nettype none

module bge_cycle_timer #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic last
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;

	assign cnt_d = load ? load_val : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
	assign last = (cnt_q == W'(1));

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

`default_nettype wire

//--- hw/bge_exec.sv
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Accumulator compare, branch if unequal, set NZVC
// - Accumulator/register compare: four taken, three not
// - Register or memory compare, byte or word
// - Memory compare: five/four plus addressing correction
// - Byte decrement, write back, branch if nonzero
// - Word decrement, same flags and write-back
// - Register decrement forms: five taken, four not
// - Memory decrement: six/five plus addressing correction
// - Software interrupts clear I, set S
// - Quick return costs 12+3b+2c chained, 12+6c otherwise
// - Quick return chains pending interrupt, no stacking
// - Interrupt returns restore I S T N Z V C
// - Link pushes frame, reserves locals, six cycles
// - Unlink restores frame pointer, five cycles
// - Near return pops word into PC, four cycles
// - Far return pops PC and bank, five cycles
module bge_exec (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire bge_pkg::bge_req_s req,
	input wire logic irq_pending,
	input wire logic [7:0] irq_vct,
	output logic ready,
	output logic done,
	output bge_pkg::bge_res_s res
);
	import bge_pkg::*;

	// ************************************************************
	// Operand arithmetic
	// ************************************************************
	logic ready_q;
	logic done_q;
	bge_res_s res_q;
	bge_res_s res_d;
	logic [7:0] cyc_d;
	logic timer_last;

	wire accept = start && ready_q;
	wire is_cmp = (req.op == OP_CMP_ACC) || (req.op == OP_CMP_OPND);
	wire is_dec = (req.op == OP_BYTE_DECREMENT_BRANCH_NONZERO) ||
		(req.op == OP_WORD_DECREMENT_BRANCH_NONZERO);
	wire wide = is_dec ? (req.op == OP_WORD_DECREMENT_BRANCH_NONZERO) : req.is_word;
	wire [15:0] src = (req.op == OP_CMP_ACC) ? req.acc : req.opnd;
	wire [15:0] opa = wide ? src : {8'h00, src[7:0]};
	wire [15:0] opb = is_dec ? 16'h0001 : (wide ? req.imm : {8'h00, req.imm[7:0]});
	// Both compare and decrement reduce to a - b at the chosen width
	wire [16:0] diff = {1'b0, opa} - {1'b0, opb};
	wire sa = wide ? opa[15] : opa[7];
	wire sb = wide ? opb[15] : opb[7];
	wire sd = wide ? diff[15] : diff[7];
	wire dz = wide ? (diff[15:0] == 16'h0000) : (diff[7:0] == 8'h00);
	wire dc = wide ? diff[16] : diff[8];
	wire dv = (sa != sb) && (sd != sa);
	wire taken = !dz;
	wire [15:0] br_pc = req.pc + {{8{req.rel[7]}}, req.rel};
	wire [15:0] wb_val = wide ? diff[15:0] : {8'h00, diff[7:0]};

	// ************************************************************
	// Stack and vector arithmetic
	// ************************************************************
	wire [15:0] ps_now = {9'h000, req.ccr};
	wire bge_ccr_s ccr_saved = '{i: req.stk_w0[PS_I_BIT], s: req.stk_w0[PS_S_BIT],
		t: req.stk_w0[PS_T_BIT], n: req.stk_w0[PS_N_BIT], z: req.stk_w0[PS_Z_BIT],
		v: req.stk_w0[PS_V_BIT], c: req.stk_w0[PS_C_BIT]};
	wire [7:0] swi_vct = (req.op == OP_SOFTWARE_TRAP_FIXED) ? FIXED_VCT : req.target[7:0];
	wire [23:0] swi_vec = VEC_BASE - {14'h0000, swi_vct, 2'b00};
	wire [23:0] irq_vec = VEC_BASE - {14'h0000, irq_vct, 2'b00};
	wire chain = (req.op == OP_QUICK_INTERRUPT_RETURN) && irq_pending;
	wire [15:0] link_fp = req.sp - 16'h0002;
	wire [15:0] link_sp = link_fp - {8'h00, req.imm[7:0]};
	// Correction terms, widened before summing so none can wrap
	wire [7:0] ca = {4'h0, req.corr_a};
	wire [7:0] cb3 = 8'(req.corr_b) * 8'h03;
	wire [7:0] cc2 = 8'(req.corr_c) * 8'h02;
	wire [7:0] cc6 = 8'(req.corr_c) * 8'h06;

	// ************************************************************
	// Result and cycle count
	// ************************************************************
	always_comb begin
		res_d = '0;
		res_d.pc = req.pc;
		res_d.program_bank_register = 8'h00;
		res_d.sp = req.sp;
		res_d.fp = req.fp;
		res_d.ccr = req.ccr;
		cyc_d = CYC_CMP_NOT;
		unique case (req.op)
			OP_CMP_ACC, OP_CMP_OPND: begin
				// Flags only; the difference is never stored
				res_d.ccr.n = sd;
				res_d.ccr.z = dz;
				res_d.ccr.v = dv;
				res_d.ccr.c = dc;
				res_d.taken = taken;
				res_d.pc = taken ? br_pc : req.pc;
				if (req.op == OP_CMP_OPND && req.is_mem) begin
					cyc_d = (taken ? CYC_CMPM_TAKEN : CYC_CMPM_NOT) + ca;
				end else begin
					cyc_d = taken ? CYC_CMP_TAKEN : CYC_CMP_NOT;
				end
			end
			OP_BYTE_DECREMENT_BRANCH_NONZERO, OP_WORD_DECREMENT_BRANCH_NONZERO: begin
				res_d.ccr.n = sd;
				res_d.ccr.z = dz;
				res_d.ccr.v = dv;
				res_d.wb_data = wb_val;
				res_d.wb_we = 1'b1;
				res_d.read_modify_write_marker = req.is_mem;
				res_d.taken = taken;
				res_d.pc = taken ? br_pc : req.pc;
				if (req.is_mem) begin
					cyc_d = (taken ? CYC_DECM_TAKEN : CYC_DECM_NOT) + ca;
				end else begin
					cyc_d = taken ? CYC_DEC_TAKEN : CYC_DEC_NOT;
				end
			end
			OP_SWI_VECTOR, OP_SWI_ADDR16, OP_SOFTWARE_TRAP_FAR, OP_SOFTWARE_TRAP_FIXED: begin
				res_d.ccr.i = 1'b0;
				res_d.ccr.s = 1'b1;
				res_d.sp = req.sp - FRAME_BYTES;
				res_d.push_data = ps_now;
				res_d.push_we = 1'b1;
				res_d.taken = 1'b1;
				cyc_d = CYC_INT_BASE + cc6;
				if (req.op == OP_SWI_ADDR16) begin
					res_d.pc = req.target[15:0];
				end else if (req.op == OP_SOFTWARE_TRAP_FAR) begin
					res_d.pc = req.target[15:0];
					res_d.program_bank_register = req.target[23:16];
					res_d.pcb_we = 1'b1;
				end else begin
					res_d.vec_addr = swi_vec;
					res_d.vec_fetch = 1'b1;
				end
			end
			OP_INTERRUPT_RETURN, OP_QUICK_INTERRUPT_RETURN: begin
				res_d.ccr = ccr_saved;
				res_d.taken = 1'b1;
				if (chain) begin
					// Stack frame stays in place for the chained handler
					res_d.vec_addr = irq_vec;
					res_d.vec_fetch = 1'b1;
					cyc_d = CYC_INT_BASE + cb3 + cc2;
				end else begin
					res_d.pc = req.stk_w1;
					res_d.program_bank_register = req.stk_w2[7:0];
					res_d.pcb_we = 1'b1;
					res_d.sp = req.sp + FRAME_BYTES;
					cyc_d = CYC_INT_BASE + cc6;
				end
			end
			OP_LINK: begin
				res_d.push_data = req.fp;
				res_d.push_we = 1'b1;
				res_d.fp = link_fp;
				res_d.sp = link_sp;
				cyc_d = CYC_LINK;
			end
			OP_UNLINK: begin
				res_d.fp = req.stk_w0;
				res_d.sp = req.fp + 16'h0002;
				cyc_d = CYC_UNLINK;
			end
			OP_NEAR_SUBROUTINE_RETURN: begin
				res_d.pc = req.stk_w0;
				res_d.sp = req.sp + 16'h0002;
				res_d.taken = 1'b1;
				cyc_d = CYC_RET_NEAR;
			end
			OP_FAR_SUBROUTINE_RETURN: begin
				res_d.pc = req.stk_w0;
				res_d.program_bank_register = req.stk_w1[7:0];
				res_d.pcb_we = 1'b1;
				res_d.sp = req.sp + 16'h0004;
				res_d.taken = 1'b1;
				cyc_d = CYC_RET_FAR;
			end
			default: begin
				cyc_d = CYC_CMP_NOT;
			end
		endcase
	end

	// ************************************************************
	// Sequencing
	// ************************************************************
	// The timer is loaded with one less so the done flop lands on the last cycle
	bge_cycle_timer #(
		.W(CNT_W)
	) u_timer (
		.clk(clk),
		.sys_rst(sys_rst),
		.load(accept),
		.load_val(cyc_d - 8'h01),
		.last(timer_last)
	);

	wire done_d = timer_last && !ready_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ready_q <= 1'b1;
			done_q <= 1'b0;
			res_q <= '0;
		end else begin
			ready_q <= accept ? 1'b0 : (done_q ? 1'b1 : ready_q);
			done_q <= done_d;
			if (accept) begin
				res_q <= res_d;
			end
		end
	end

	assign ready = ready_q;
	assign done = done_q;
	assign res = res_q;

	// ************************************************************
	// Checks
	// ************************************************************
	logic [7:0] busy_cnt_q;
	logic [7:0] exp_cyc_q;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			busy_cnt_q <= 8'h00;
			exp_cyc_q <= 8'h00;
		end else if (accept) begin
			busy_cnt_q <= 8'h01;
			exp_cyc_q <= cyc_d;
		end else if (!ready_q && !done_q) begin
			busy_cnt_q <= busy_cnt_q + 8'h01;
		end
	end

	property p_cmp_acc_taken;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_CMP_ACC && opa != opb |->
			##1 !done_q[*3] ##1 done_q;
	endproperty
	a_cmp_acc_taken: assert property (p_cmp_acc_taken) else $error("compare taken not 4");

	property p_cmp_reg_not;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_CMP_OPND && !req.is_mem && opa == opb |->
			##1 !done_q[*2] ##1 done_q ##1 ready_q;
	endproperty
	a_cmp_reg_not: assert property (p_cmp_reg_not) else $error("compare untaken not 3");

	property p_cmp_branch;
		@(posedge clk) disable iff (sys_rst)
		accept && is_cmp |-> ##1 res_q.taken == ($past(opa) != $past(opb)) && !res_q.wb_we;
	endproperty
	a_cmp_branch: assert property (p_cmp_branch) else $error("compare branch wrong");

	property p_cmp_carry;
		@(posedge clk) disable iff (sys_rst)
		accept && is_cmp |-> ##1 res_q.ccr.c == ($past(opa) < $past(opb));
	endproperty
	a_cmp_carry: assert property (p_cmp_carry) else $error("compare borrow wrong");

	property p_dec_carry_kept;
		@(posedge clk) disable iff (sys_rst)
		accept && is_dec |-> ##1 res_q.ccr.c == $past(req.ccr.c) &&
			res_q.wb_data == $past(wb_val) && res_q.taken == (res_q.wb_data != 16'h0000);
	endproperty
	a_dec_carry_kept: assert property (p_dec_carry_kept) else $error("decrement flags wrong");

	property p_cycle_total;
		@(posedge clk) disable iff (sys_rst)
		done_q |-> busy_cnt_q == exp_cyc_q;
	endproperty
	a_cycle_total: assert property (p_cycle_total) else $error("cycle count mismatch");

	property p_swi_flags;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op inside {OP_SWI_VECTOR, OP_SWI_ADDR16, OP_SOFTWARE_TRAP_FAR,
			OP_SOFTWARE_TRAP_FIXED} |-> ##1 !res_q.ccr.i && res_q.ccr.s &&
			res_q.ccr.n == $past(req.ccr.n);
	endproperty
	a_swi_flags: assert property (p_swi_flags) else $error("trap flags wrong");

	property p_quick_chain;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_QUICK_INTERRUPT_RETURN && irq_pending |->
			##1 res_q.vec_fetch && res_q.sp == $past(req.sp) && !res_q.pcb_we;
	endproperty
	a_quick_chain: assert property (p_quick_chain) else $error("quick return did not chain");

	property p_link;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_LINK |-> ##1 res_q.fp == $past(req.sp) - 16'h0002 &&
			res_q.push_data == $past(req.fp) ##5 done_q;
	endproperty
	a_link: assert property (p_link) else $error("link frame wrong");

	property p_far_ret;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_FAR_SUBROUTINE_RETURN |->
			##1 res_q.program_bank_register == $past(req.stk_w1[7:0]) && res_q.sp == $past(req.sp) + 16'h0004
			##4 done_q;
	endproperty
	a_far_ret: assert property (p_far_ret) else $error("far return wrong");

	property p_cmp_mem_cycles;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_CMP_OPND && req.is_mem |->
			##1 exp_cyc_q == (res_q.taken ? CYC_CMPM_TAKEN : CYC_CMPM_NOT) +
			{4'h0, $past(req.corr_a)};
	endproperty
	a_cmp_mem_cycles: assert property (p_cmp_mem_cycles) else $error("mem compare time");

	property p_dec_reg_cycles;
		@(posedge clk) disable iff (sys_rst)
		accept && is_dec && !req.is_mem |->
			##1 exp_cyc_q == (res_q.taken ? CYC_DEC_TAKEN : CYC_DEC_NOT);
	endproperty
	a_dec_reg_cycles: assert property (p_dec_reg_cycles) else $error("reg decrement time");

	// Chained and plain quick returns are priced from different corrections
	property p_quick_cycles;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_QUICK_INTERRUPT_RETURN |->
			##1 exp_cyc_q == CYC_INT_BASE + (res_q.vec_fetch ?
			8'h03 * {4'h0, $past(req.corr_b)} + 8'h02 * {4'h0, $past(req.corr_c)} :
			8'h06 * {4'h0, $past(req.corr_c)});
	endproperty
	a_quick_cycles: assert property (p_quick_cycles) else $error("quick return time");

	property p_ret_restore;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op inside {OP_INTERRUPT_RETURN, OP_QUICK_INTERRUPT_RETURN} |->
			##1 res_q.ccr == $past(req.stk_w0[PS_I_BIT:PS_C_BIT]);
	endproperty
	a_ret_restore: assert property (p_ret_restore) else $error("return flags wrong");

	property p_unlink;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_UNLINK |->
			##1 res_q.fp == $past(req.stk_w0) && res_q.sp == $past(req.fp) + 16'h0002
			##4 done_q;
	endproperty
	a_unlink: assert property (p_unlink) else $error("unlink wrong");

	property p_near_ret;
		@(posedge clk) disable iff (sys_rst)
		accept && req.op == OP_NEAR_SUBROUTINE_RETURN |->
			##1 res_q.pc == $past(req.stk_w0) && res_q.sp == $past(req.sp) + 16'h0002
			##3 done_q;
	endproperty
	a_near_ret: assert property (p_near_ret) else $error("near return wrong");

endmodule

`default_nettype wire

//--- verif/bge_stack_model.sv
`timescale 1ns/10ps
`default_nettype none

// ************************************************************
// Stack memory that feeds the executor and takes its pushes
// ************************************************************
module bge_stack_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [15:0] addr,
	input wire logic wr,
	input wire logic [15:0] wr_addr,
	input wire logic [15:0] wr_data,
	output logic [15:0] w0,
	output logic [15:0] w1,
	output logic [15:0] w2
);
	// Eight words that wrap: enough for one frame and cheap to reset
	logic [15:0] mem_q [8];

	assign w0 = mem_q[addr[3:1]];
	assign w1 = mem_q[3'(addr[3:1] + 3'h1)];
	assign w2 = mem_q[3'(addr[3:1] + 3'h2)];

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int k = 0; k < 8; k++) begin
				mem_q[k] <= 16'h0055 + 16'(k) * 16'h1fdf;
			end
		end else if (wr) begin
			mem_q[wr_addr[3:1]] <= wr_data;
		end
	end
endmodule

`default_nettype wire

//--- verif/tb_branch_group_two_execution.sv
`timescale 1ns/10ps
`default_nettype none

module tb_branch_group_two_execution;
	import bge_pkg::*;

	// ************************************************************
	// Rows: f = {word, mem, irq, check pc and taken, taken}
	// ************************************************************
	typedef struct packed {
		bge_op_e op;
		logic [4:0] f;
		logic [15:0] acc, opnd, imm;
		logic [11:0] cor;
		logic [7:0] n;
		logic [15:0] pc, sp, fp;
		logic [6:0] ccr;
		logic [16:0] wb;
	} bge_row_s;

	bge_row_s rows [19] = '{
		'{OP_CMP_OPND, 5'h12, 16'h0000, 16'h8000, 16'h8000, 12'h000, 8'h03, 16'h1000, 16'h0800, 16'h080e, 7'h54, 17'h00000},
		'{OP_CMP_ACC, 5'h02, 16'h3412, 16'h0000, 16'h0012, 12'h000, 8'h03, 16'h1000, 16'h0800, 16'h080e, 7'h54, 17'h00000},
		'{OP_CMP_ACC, 5'h13, 16'h0001, 16'h0000, 16'h0002, 12'h000, 8'h04, 16'h1010, 16'h0800, 16'h080e, 7'h59, 17'h00000},
		'{OP_CMP_OPND, 5'h03, 16'h0000, 16'h0080, 16'h0001, 12'h000, 8'h04, 16'h1010, 16'h0800, 16'h080e, 7'h52, 17'h00000},
		'{OP_CMP_OPND, 5'h1a, 16'h0000, 16'h1234, 16'h1234, 12'h200, 8'h06, 16'h1000, 16'h0800, 16'h080e, 7'h54, 17'h00000},
		'{OP_CMP_OPND, 5'h0b, 16'h0000, 16'h0000, 16'h0001, 12'h100, 8'h06, 16'h1010, 16'h0800, 16'h080e, 7'h59, 17'h00000},
		'{OP_BYTE_DECREMENT_BRANCH_NONZERO, 5'h02, 16'h0000, 16'hab01, 16'h0000, 12'h000, 8'h04, 16'h1000, 16'h0800, 16'h080e, 7'h55, 17'h10000},
		'{OP_BYTE_DECREMENT_BRANCH_NONZERO, 5'h0b, 16'h0000, 16'h0080, 16'h0000, 12'h300, 8'h09, 16'h1010, 16'h0800, 16'h080e, 7'h53, 17'h1007f},
		'{OP_WORD_DECREMENT_BRANCH_NONZERO, 5'h13, 16'h0000, 16'h0000, 16'h0000, 12'h000, 8'h05, 16'h1010, 16'h0800, 16'h080e, 7'h59, 17'h1ffff},
		'{OP_WORD_DECREMENT_BRANCH_NONZERO, 5'h1b, 16'h0000, 16'h8000, 16'h0000, 12'h200, 8'h08, 16'h1010, 16'h0800, 16'h080e, 7'h53, 17'h17fff},
		'{OP_SWI_VECTOR, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h001, 8'h12, 16'h1000, 16'h07f4, 16'h080e, 7'h31, 17'h00000},
		'{OP_SWI_ADDR16, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h001, 8'h12, 16'h1000, 16'h07f4, 16'h080e, 7'h31, 17'h00000},
		'{OP_SOFTWARE_TRAP_FAR, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h001, 8'h12, 16'h1000, 16'h07f4, 16'h080e, 7'h31, 17'h00000},
		'{OP_INTERRUPT_RETURN, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h001, 8'h12, 16'h1000, 16'h080c, 16'h080e, 7'h55, 17'h00000},
		'{OP_QUICK_INTERRUPT_RETURN, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h002, 8'h18, 16'h1000, 16'h080c, 16'h080e, 7'h55, 17'h00000},
		'{OP_LINK, 5'h00, 16'h0000, 16'h0000, 16'h0004, 12'h000, 8'h06, 16'h1000, 16'h07fa, 16'h07fe, 7'h51, 17'h00000},
		'{OP_UNLINK, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h000, 8'h05, 16'h1000, 16'h0810, 16'h080e, 7'h51, 17'h00000},
		'{OP_NEAR_SUBROUTINE_RETURN, 5'h03, 16'h0000, 16'h0000, 16'h0000, 12'h000, 8'h04, 16'h0055, 16'h0802, 16'h080e, 7'h51, 17'h00000},
		'{OP_FAR_SUBROUTINE_RETURN, 5'h03, 16'h0000, 16'h0000, 16'h0000, 12'h000, 8'h05, 16'h0055, 16'h0804, 16'h080e, 7'h51, 17'h00000}
	};
	localparam bge_row_s row_chain = '{OP_QUICK_INTERRUPT_RETURN, 5'h04, 16'h0000, 16'h0000, 16'h0000, 12'h011, 8'h11, 16'h1000, 16'h0800, 16'h080e, 7'h55, 17'h00000};
	localparam bge_row_s row_fixed = '{OP_SOFTWARE_TRAP_FIXED, 5'h00, 16'h0000, 16'h0000, 16'h0000, 12'h001, 8'h12, 16'h1000, 16'h07f4, 16'h080e, 7'h31, 17'h00000};

	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic start = 1'b0;
	bge_row_s cur = '0;
	bge_req_s req;
	bge_res_s res;
	logic ready, done;
	logic [15:0] w0, w1, w2;
	int fails = 0;
	int comparisons = 0;
	int cycles = 0;

	// Fixed context; stack words come from the model, unlink reads at the frame
	assign req = '{op: cur.op, is_word: cur.f[4], is_mem: cur.f[3], acc: cur.acc, opnd: cur.opnd,
		imm: cur.imm, rel: 8'h10, pc: 16'h1000, sp: 16'h0800, fp: 16'h080e, target: 24'h000003,
		stk_w0: w0, stk_w1: w1, stk_w2: w2, corr_a: cur.cor[11:8], corr_b: cur.cor[7:4],
		corr_c: cur.cor[3:0], ccr: 7'h51};

	bge_exec dut_u (.clk(clk), .sys_rst(sys_rst), .start(start), .req(req), .irq_pending(cur.f[2]),
		.irq_vct(8'h03), .ready(ready), .done(done), .res(res));

	bge_stack_model model_u (.clk(clk), .sys_rst(sys_rst),
		.addr(cur.op == OP_UNLINK ? 16'h080e : 16'h0800), .wr(res.push_we && done),
		.wr_addr(res.fp), .wr_data(res.push_data), .w0(w0), .w1(w1), .w2(w2));

	initial begin
		forever #20 clk = ~clk;
	end

	// ************************************************************
	// Checking and run control
	// ************************************************************
	task results;
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Bounded so a lost done cannot hang the run
	task automatic wait_done(output int n);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 80);
	endtask

	task automatic run(input bge_row_s r);
		int n;
		@(posedge clk);
		cur <= r;
		start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		wait_done(n);
		chk("cycles", n, r.n);
		chk("ccr", res.ccr, r.ccr);
		chk("sp", res.sp, r.sp);
		chk("fp", res.fp, r.fp);
		chk("wb", res.wb_we ? {1'b1, res.wb_data} : 17'h0, r.wb);
		chk("rmw", res.read_modify_write_marker, r.f[3] && (r.op inside
			{OP_BYTE_DECREMENT_BRANCH_NONZERO, OP_WORD_DECREMENT_BRANCH_NONZERO}));
		if (r.f[1]) begin
			chk("taken", res.taken, r.f[0]);
			chk("pc", res.pc, r.pc);
		end
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fails = fails + 1;
			results;
		end
	end

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		int n;
		repeat (5) @(posedge clk);
		@(negedge clk);
		chk("ready_rst", ready, 1'b1);
		chk("done_rst", done, 1'b0);
		chk("res_rst", res === '0, 1'b1);
		@(posedge clk) sys_rst <= 1'b0;
		foreach (rows[i]) run(rows[i]);
		chk("bank_we", res.pcb_we, 1'b1);
		chk("bank", res.program_bank_register, 8'h34);
		run(row_chain);
		chk("vec_fetch", res.vec_fetch, 1'b1);
		chk("vec_chain", res.vec_addr, 24'hfffff0);
		run(row_fixed);
		chk("vec_fixed", res.vec_addr, 24'hffffd8);
		// Start held high: ignored while busy, taken again right after done
		@(posedge clk);
		cur <= rows[17];
		start <= 1'b1;
		@(posedge clk);
		wait_done(n);
		chk("busy", n, 4);
		// Ready is back only after the done edge, so start must span one more edge
		@(posedge clk);
		@(posedge clk) start <= 1'b0;
		wait_done(n);
		chk("next", n, 4);
		// Reset in mid-instruction, then run again
		@(posedge clk);
		cur <= rows[15];
		start <= 1'b1;
		@(posedge clk) start <= 1'b0;
		@(posedge clk) sys_rst <= 1'b1;
		@(negedge clk);
		chk("ready_mid", ready, 1'b1);
		chk("done_mid", done, 1'b0);
		chk("res_mid", res === '0, 1'b1);
		@(posedge clk) sys_rst <= 1'b0;
		run(rows[15]);
		results;
	end
endmodule

`default_nettype wire
